// [modem_regs_pkg.sv]
`default_nettype none
package modem_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODEM_CONTROL_SECOND = 8'h12;
    localparam logic [7:0] IDX_SIGNAL_STRENGTH_CCA = 8'h13;
    localparam logic [7:0] IDX_SYNC_PATTERN = 8'h14;
    localparam logic [7:0] IDX_CCA_CONFIG = 8'h20;
    localparam logic [7:0] IDX_RX_STATUS = 8'h21;
    localparam logic [7:0] ADDR_MODEM_CONTROL_SECOND = {IDX_MODEM_CONTROL_SECOND[5:0], 2'b00};
    localparam logic [7:0] ADDR_SIGNAL_STRENGTH_CCA = {IDX_SIGNAL_STRENGTH_CCA[5:0], 2'b00};
    localparam logic [7:0] ADDR_SYNC_PATTERN = {IDX_SYNC_PATTERN[5:0], 2'b00};
    localparam logic [7:0] ADDR_CCA_CONFIG = {IDX_CCA_CONFIG[5:0], 2'b00};
    localparam logic [7:0] ADDR_RX_STATUS = {IDX_RX_STATUS[5:0], 2'b00};

    // field positions
    localparam int CTRL_WIDTH = 11;
    localparam int CLEAR_CHANNEL_THRESHOLD_LSB = 8;
    localparam int CLEAR_CHANNEL_HYSTERESIS_LSB = 0;
    localparam int CLEAR_CHANNEL_MODE_LSB = 4;

    // values after reset, and the advised correlator threshold
    localparam logic [4:0] CORRELATOR_THRESHOLD_RESET = 5'h00;
    localparam logic [4:0] CORRELATOR_THRESHOLD_ADVISED = 5'h14;
    localparam logic [7:0] CLEAR_CHANNEL_THRESHOLD_RESET = 8'he0;
    localparam logic [7:0] SIGNAL_STRENGTH_CCA_INVALID = 8'h80;
    localparam logic [15:0] SYNC_RESET = 16'ha70f;
    localparam logic [2:0] CLEAR_CHANNEL_HYSTERESIS_RESET = 3'h2;
    localparam logic [1:0] CLEAR_CHANNEL_MODE_RESET = 2'h3;

    // counts and special nibble values
    localparam logic [2:0] AVG_LAST_SYMBOL = 3'h7;
    localparam logic [2:0] SYNC_HISTORY = 3'h5;
    localparam logic [3:0] NIBBLE_DONT_CARE = 4'hf;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;

    typedef enum logic [1:0] {
        TX_BUFFERED = 2'h0,
        TX_SERIAL = 2'h1,
        TX_FIFO_LOOP = 2'h2,
        TX_PRBS = 2'h3
    } tx_mode_e;

    typedef enum logic [1:0] {
        RX_BUFFERED = 2'h0,
        RX_SERIAL = 2'h1,
        RX_FIFO_LOOP = 2'h2,
        RX_RESERVED = 2'h3
    } rx_mode_e;

    typedef enum logic [1:0] {
        CCA_RESERVED = 2'h0,
        CCA_LEVEL = 2'h1,
        CCA_NO_PACKET = 2'h2,
        CCA_BOTH = 2'h3
    } clear_channel_mode_e;

    // layout of modem_control_second bits 10:0
    typedef struct packed {
        logic [4:0] correlator_threshold;
        logic freq_offset_filter_mode;
        logic phase_reversed;
        tx_mode_e tx_mode;
        rx_mode_e rx_mode;
    } modem_ctrl_s;
endpackage
`default_nettype wire

// [sync_nibble_engine.sv]
`default_nettype none
module sync_nibble_engine
    import modem_regs_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // configuration
    input wire logic [15:0] SYNC_WORD,
    input wire logic SEARCH_EN,
    // modulator side
    input wire logic SYMBOL_TICK,
    input wire logic TX_START,
    output logic [3:0] TX_SYMBOL,
    output logic TX_STROBE,
    output logic TX_DONE,
    // demodulator side
    input wire logic [3:0] RX_SYMBOL,
    input wire logic RX_SYMBOL_VALID,
    output logic FRAME_SYNC
);
    typedef enum {TXS_IDLE, TXS_SEND} tx_state_e;

    tx_state_e state_r;
    logic [1:0] idx_r;
    logic [3:0] nib;
    logic [3:0] hist_r [0:4];
    logic [2:0] fill_r;
    logic shifted_r;
    logic [3:0] ok;
    logic match;

    assign nib = SYNC_WORD[{idx_r, 2'b00} +: 4];

    // least significant nibble goes out first
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= TXS_IDLE;
            idx_r <= 2'h0;
            TX_SYMBOL <= 4'h0;
            TX_STROBE <= 1'b0;
            TX_DONE <= 1'b0;
        end
        else
        begin
            TX_STROBE <= 1'b0;
            TX_DONE <= 1'b0;
            case (state_r)
                TXS_IDLE:
                begin
                    idx_r <= 2'h0;
                    if (TX_START)
                        state_r <= TXS_SEND;
                end
                TXS_SEND:
                begin
                    if (SYMBOL_TICK)
                    begin
                        TX_SYMBOL <= (nib == NIBBLE_DONT_CARE) ? NIBBLE_ZERO : nib;
                        TX_STROBE <= 1'b1;
                        idx_r <= idx_r + 2'h1;
                        if (idx_r == 2'h3)
                        begin
                            state_r <= TXS_IDLE;
                            TX_DONE <= 1'b1;
                        end
                    end
                end
                default: state_r <= TXS_IDLE;
            endcase
        end
    end

    // hist_r[0] is the newest symbol; hist_r[4] must be the implicit zero
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_nib
            assign ok[g] = (SYNC_WORD[4*g +: 4] == NIBBLE_DONT_CARE) ||
                (hist_r[3-g] == SYNC_WORD[4*g +: 4]);
        end
    endgenerate

    assign match = (&ok) && (hist_r[4] == NIBBLE_ZERO) && (fill_r == SYNC_HISTORY);

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            for (int i = 0; i < 5; i++)
                hist_r[i] <= 4'h0;
            fill_r <= 3'h0;
            shifted_r <= 1'b0;
            FRAME_SYNC <= 1'b0;
        end
        else
        begin
            shifted_r <= RX_SYMBOL_VALID;
            FRAME_SYNC <= shifted_r && SEARCH_EN && match;
            if (RX_SYMBOL_VALID)
            begin
                hist_r[0] <= RX_SYMBOL;
                for (int i = 1; i < 5; i++)
                    hist_r[i] <= hist_r[i-1];
            end
            // restart after a hit so one delimiter is not reported twice
            if (shifted_r && SEARCH_EN && match)
                fill_r <= 3'h0;
            else if (RX_SYMBOL_VALID && fill_r != SYNC_HISTORY)
                fill_r <= fill_r + 3'h1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    no_f_out_a: assert property (TX_STROBE |-> TX_SYMBOL != NIBBLE_DONT_CARE)
        else $error("sync nibble 0xf was transmitted");
    four_nibbles_a: assert property (TX_DONE |-> TX_STROBE && $past(idx_r) == 2'h3)
        else $error("sync word did not end on the fourth nibble");
    sync_needs_zero_a: assert property (FRAME_SYNC |-> $past(hist_r[4]) == NIBBLE_ZERO)
        else $error("frame sync without preceding zero symbol");
endmodule // sync_nibble_engine
`default_nettype wire

// [modem_ctrl_signal_strength_cca_sync_regs.sv]
// Decided for this implementation: the APB register port.
`default_nettype none
// Summary of operation
// - 5-bit correlator threshold gates delimiter search; resets 0, advise 20.
// - averaging bit 0 freezes offset filter at preamble match; 1 keeps updating.
// - polarity bit 1 reverses modulation phase for transmit and receive.
// - transmit mode 0 sends buffered data from the transmit queue.
// - transmit mode 1 sends serial-port data endlessly, lab use.
// - transmit mode 2 loops the transmit queue, ignores underflow, endless.
// - transmit mode 3 sends CRC pseudo-random data endlessly.
// - receive mode 0 stores received data in the receive queue.
// - receive mode 1 puts received data on pins, receives endlessly.
// - receive mode 2 loops the receive queue ignoring overflow; 3 reserved.
// - 8-bit signed clear-channel threshold in dB, resets to -32.
// - clear-channel output high while signal below threshold, on a pin.
// - read-only signed signal-strength estimate in status low byte.
// - estimate averages 8 symbols; valid flag after 8 enabled symbols.
// - estimate reads -128 after reset, meaning invalid.
// - 16-bit sync word resets to 0xa70f, least significant nibble first.
// - transmitted sync nibbles 0xf become 0x0.
// - received sync nibbles 0xf are don't-care.
// - receive needs an implicit zero symbol before the sync word.
// - level mode: set below threshold minus hysteresis, clear at threshold.
module modem_ctrl_signal_strength_cca_sync_regs
    import modem_regs_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // receiver status from the demodulator
    input wire logic RX_ENABLE,
    input wire logic SYMBOL_TICK,
    input wire logic [7:0] SIGNAL_STRENGTH_CCA_SAMPLE,
    input wire logic [4:0] CORR_MAG,
    input wire logic PREAMBLE_MATCH,
    input wire logic RX_PACKET_ACTIVE,
    input wire logic [3:0] RX_SYMBOL,
    input wire logic RX_SYMBOL_VALID,
    // demodulator and modulator control
    output logic SFD_SEARCH_EN,
    output logic FREQ_FILTER_HOLD,
    output logic PHASE_REVERSED,
    output logic FRAME_SYNC,
    input wire logic TX_SYNC_START,
    output logic [3:0] TX_SYNC_SYMBOL,
    output logic TX_SYNC_STROBE,
    output logic TX_SYNC_DONE,
    // transmit data source
    output logic TX_SRC_QUEUE,
    output logic TX_SRC_SERIAL,
    output logic TX_QUEUE_LOOP,
    output logic TX_SRC_PRBS,
    output logic TX_ENDLESS,
    // receive data sink
    output logic RX_TO_QUEUE,
    output logic RX_TO_PINS,
    output logic RX_QUEUE_LOOP,
    output logic RX_ENDLESS,
    // clear channel pin
    output logic CCA_PIN
);
    modem_ctrl_s ctrl_r;
    logic [7:0] clear_channel_threshold_r;
    logic [15:0] sync_r;
    logic [2:0] hyst_r;
    clear_channel_mode_e clear_channel_mode_r;
    logic [7:0] est_r;
    logic valid_r;
    logic signed [10:0] acc_r;
    logic signed [10:0] sum_nxt;
    logic [2:0] cnt_r;
    logic cca_level_r;
    logic cca_level_nxt;
    logic cca_nxt;
    logic signed [8:0] low_lim;
    logic below_low;
    logic at_or_above;
    logic apb_access;
    logic apb_write;
    logic [31:0] rdata_nxt;
    logic mapped;

    // one wait state: data is registered at the first access cycle
    assign apb_access = PSEL && PENABLE && !PREADY;
    assign apb_write = PSEL && PENABLE && PREADY && PWRITE;

    always_comb
    begin
        rdata_nxt = 32'h0;
        mapped = 1'b1;
        case (PADDR)
            ADDR_MODEM_CONTROL_SECOND: rdata_nxt = {21'h0, ctrl_r};
            ADDR_SIGNAL_STRENGTH_CCA: rdata_nxt = {16'h0, clear_channel_threshold_r, est_r};
            ADDR_SYNC_PATTERN: rdata_nxt = {16'h0, sync_r};
            ADDR_CCA_CONFIG: rdata_nxt = {26'h0, clear_channel_mode_r, 1'b0, hyst_r};
            ADDR_RX_STATUS: rdata_nxt = {29'h0, FREQ_FILTER_HOLD, CCA_PIN, valid_r};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= apb_access;
            if (apb_access)
            begin
                PRDATA <= PWRITE ? 32'h0 : rdata_nxt;
                PSLVERR <= !mapped;
            end
            else
            begin
                PSLVERR <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_r <= modem_ctrl_s'({CORRELATOR_THRESHOLD_RESET, 6'h00});
            clear_channel_threshold_r <= CLEAR_CHANNEL_THRESHOLD_RESET;
            sync_r <= SYNC_RESET;
            hyst_r <= CLEAR_CHANNEL_HYSTERESIS_RESET;
            clear_channel_mode_r <= clear_channel_mode_e'(CLEAR_CHANNEL_MODE_RESET);
        end
        else if (apb_write)
        begin
            case (PADDR)
                // upper bits are not stored, so a careless write cannot leak into them
                ADDR_MODEM_CONTROL_SECOND: ctrl_r <= modem_ctrl_s'(PWDATA[CTRL_WIDTH-1:0]);
                ADDR_SIGNAL_STRENGTH_CCA: clear_channel_threshold_r <= PWDATA[CLEAR_CHANNEL_THRESHOLD_LSB +: 8];
                ADDR_SYNC_PATTERN: sync_r <= PWDATA[15:0];
                ADDR_CCA_CONFIG:
                begin
                    hyst_r <= PWDATA[CLEAR_CHANNEL_HYSTERESIS_LSB +: 3];
                    clear_channel_mode_r <= clear_channel_mode_e'(PWDATA[CLEAR_CHANNEL_MODE_LSB +: 2]);
                end
                default: ;
            endcase
        end
    end

    // mode decode; reserved receive mode 3 falls back to buffered reception
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            TX_SRC_QUEUE <= 1'b1;
            TX_SRC_SERIAL <= 1'b0;
            TX_QUEUE_LOOP <= 1'b0;
            TX_SRC_PRBS <= 1'b0;
            TX_ENDLESS <= 1'b0;
            RX_TO_QUEUE <= 1'b1;
            RX_TO_PINS <= 1'b0;
            RX_QUEUE_LOOP <= 1'b0;
            RX_ENDLESS <= 1'b0;
            PHASE_REVERSED <= 1'b0;
        end
        else
        begin
            TX_SRC_QUEUE <= ctrl_r.tx_mode == TX_BUFFERED || ctrl_r.tx_mode == TX_FIFO_LOOP;
            TX_SRC_SERIAL <= ctrl_r.tx_mode == TX_SERIAL;
            TX_QUEUE_LOOP <= ctrl_r.tx_mode == TX_FIFO_LOOP;
            TX_SRC_PRBS <= ctrl_r.tx_mode == TX_PRBS;
            TX_ENDLESS <= ctrl_r.tx_mode != TX_BUFFERED;
            RX_TO_QUEUE <= ctrl_r.rx_mode != RX_SERIAL;
            RX_TO_PINS <= ctrl_r.rx_mode == RX_SERIAL;
            RX_QUEUE_LOOP <= ctrl_r.rx_mode == RX_FIFO_LOOP;
            RX_ENDLESS <= ctrl_r.rx_mode == RX_SERIAL || ctrl_r.rx_mode == RX_FIFO_LOOP;
            PHASE_REVERSED <= ctrl_r.phase_reversed;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            SFD_SEARCH_EN <= 1'b0;
            FREQ_FILTER_HOLD <= 1'b0;
        end
        else
        begin
            SFD_SEARCH_EN <= RX_ENABLE && (CORR_MAG >= ctrl_r.correlator_threshold);
            if (!RX_ENABLE || ctrl_r.freq_offset_filter_mode)
                FREQ_FILTER_HOLD <= 1'b0;
            else if (PREAMBLE_MATCH)
                FREQ_FILTER_HOLD <= 1'b1;
        end
    end

    // eight samples of -128..127 fit an 11-bit signed sum
    assign sum_nxt = acc_r + 11'(signed'(SIGNAL_STRENGTH_CCA_SAMPLE));

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            acc_r <= 11'sh0;
            cnt_r <= 3'h0;
            est_r <= SIGNAL_STRENGTH_CCA_INVALID;
            valid_r <= 1'b0;
        end
        else if (!RX_ENABLE)
        begin
            acc_r <= 11'sh0;
            cnt_r <= 3'h0;
            est_r <= SIGNAL_STRENGTH_CCA_INVALID;
            valid_r <= 1'b0;
        end
        else if (SYMBOL_TICK)
        begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == AVG_LAST_SYMBOL)
            begin
                est_r <= sum_nxt[10:3];
                valid_r <= 1'b1;
                acc_r <= 11'sh0;
            end
            else
            begin
                acc_r <= sum_nxt;
            end
        end
    end

    assign low_lim = $signed({clear_channel_threshold_r[7], clear_channel_threshold_r}) - $signed({6'h0, hyst_r});
    assign below_low = $signed({est_r[7], est_r}) < low_lim;
    assign at_or_above = $signed(est_r) >= $signed(clear_channel_threshold_r);

    always_comb
    begin
        cca_level_nxt = cca_level_r;
        if (below_low)
            cca_level_nxt = 1'b1;
        else if (at_or_above)
            cca_level_nxt = 1'b0;
        case (clear_channel_mode_r)
            CCA_NO_PACKET: cca_nxt = !RX_PACKET_ACTIVE;
            CCA_BOTH: cca_nxt = cca_level_nxt && !RX_PACKET_ACTIVE;
            default: cca_nxt = cca_level_nxt;
        endcase
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cca_level_r <= 1'b0;
            CCA_PIN <= 1'b0;
        end
        else
        begin
            cca_level_r <= cca_level_nxt;
            CCA_PIN <= cca_nxt;
        end
    end

    sync_nibble_engine u_sync (
        .MCLK(MCLK),
        .RST(RST),
        .SYNC_WORD(sync_r),
        .SEARCH_EN(SFD_SEARCH_EN),
        .SYMBOL_TICK(SYMBOL_TICK),
        .TX_START(TX_SYNC_START),
        .TX_SYMBOL(TX_SYNC_SYMBOL),
        .TX_STROBE(TX_SYNC_STROBE),
        .TX_DONE(TX_SYNC_DONE),
        .RX_SYMBOL(RX_SYMBOL),
        .RX_SYMBOL_VALID(RX_SYMBOL_VALID),
        .FRAME_SYNC(FRAME_SYNC)
    );

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    ctrl_upper_zero_a: assert property (
        apb_access && !PWRITE && PADDR == ADDR_MODEM_CONTROL_SECOND |=> PRDATA[31:11] == 21'h0)
        else $error("reserved control bits read nonzero");
    sfd_gate_a: assert property (
        RX_ENABLE && CORR_MAG < ctrl_r.correlator_threshold |=> !SFD_SEARCH_EN)
        else $error("delimiter search enabled below threshold");
    freq_lock_a: assert property (
        RX_ENABLE && PREAMBLE_MATCH && !ctrl_r.freq_offset_filter_mode |=> FREQ_FILTER_HOLD)
        else $error("offset filter not frozen after preamble");
    prbs_select_a: assert property (
        ctrl_r.tx_mode == TX_PRBS |=> TX_SRC_PRBS && TX_ENDLESS && !TX_SRC_QUEUE)
        else $error("pseudo-random transmit mode not decoded");
    rx_pins_a: assert property (
        ctrl_r.rx_mode == RX_SERIAL |=> RX_TO_PINS && RX_ENDLESS && !RX_TO_QUEUE)
        else $error("serial receive mode not decoded");
    signal_strength_cca_invalid_a: assert property (
        !RX_ENABLE |=> est_r == SIGNAL_STRENGTH_CCA_INVALID && !valid_r)
        else $error("estimate not invalid with receiver off");
    valid_eighth_a: assert property (
        $rose(valid_r) |-> $past(cnt_r) == AVG_LAST_SYMBOL && $past(SYMBOL_TICK))
        else $error("valid flag not on eighth symbol");
    cca_level_a: assert property (
        clear_channel_mode_r == CCA_LEVEL && below_low |=> CCA_PIN ##0 $past(clear_channel_mode_r) == CCA_LEVEL)
        else $error("clear channel not set below threshold");
    cca_clear_a: assert property (
        clear_channel_mode_r == CCA_LEVEL && at_or_above && !below_low |=> !CCA_PIN)
        else $error("clear channel not cleared at threshold");
    est_hw_only_a: assert property (
        apb_write && PADDR == ADDR_SIGNAL_STRENGTH_CCA && RX_ENABLE && !SYMBOL_TICK
        |=> $stable(est_r))
        else $error("host write changed the estimate");
endmodule // modem_ctrl_signal_strength_cca_sync_regs
`default_nettype wire

// [host_apb_model.sv]
`default_nettype none
module host_apb_model
    import modem_regs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // commands from the bench
    input wire logic req,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 8'h00;
            pwdata <= 32'h0;
            done <= 1'b0;
            rdata <= 32'h0;
            err <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (psel && penable && pready)
            begin
                psel <= 1'b0;
                penable <= 1'b0;
                done <= 1'b1;
                rdata <= prdata;
                err <= pslverr;
                // released bus must not keep showing the old request
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end
            else if (psel)
                penable <= 1'b1;
            else if (req)
            begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= (addr == ADDR_MODEM_CONTROL_SECOND) ? {21'h0, wdata[10:0]} : wdata;
            end
        end
    end
endmodule // host_apb_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb
    import modem_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [7:0] PADDR, SIGNAL_STRENGTH_CCA_SAMPLE, addr;
    logic [31:0] PWDATA, PRDATA, wdata, rdata;
    logic RX_ENABLE, SYMBOL_TICK, PREAMBLE_MATCH, RX_PACKET_ACTIVE, RX_SYMBOL_VALID;
    logic [4:0] CORR_MAG;
    logic [3:0] RX_SYMBOL, TX_SYNC_SYMBOL;
    logic SFD_SEARCH_EN, FREQ_FILTER_HOLD, PHASE_REVERSED, FRAME_SYNC, TX_SYNC_START;
    logic TX_SYNC_STROBE, TX_SYNC_DONE, TX_SRC_QUEUE, TX_SRC_SERIAL, TX_QUEUE_LOOP;
    logic TX_SRC_PRBS, TX_ENDLESS, RX_TO_QUEUE, RX_TO_PINS, RX_QUEUE_LOOP, RX_ENDLESS, CCA_PIN;
    logic req, wr, done, err;
    int n_mismatch, checked, sync_hits, tx_done_at;
    logic [3:0] tx_seen[$];

    modem_ctrl_signal_strength_cca_sync_regs i_modem_ctrl_signal_strength_cca_sync_regs (.MCLK, .RST, .PSEL, .PENABLE,
        .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RX_ENABLE, .SYMBOL_TICK,
        .SIGNAL_STRENGTH_CCA_SAMPLE, .CORR_MAG, .PREAMBLE_MATCH, .RX_PACKET_ACTIVE, .RX_SYMBOL,
        .RX_SYMBOL_VALID, .SFD_SEARCH_EN, .FREQ_FILTER_HOLD, .PHASE_REVERSED, .FRAME_SYNC,
        .TX_SYNC_START, .TX_SYNC_SYMBOL, .TX_SYNC_STROBE, .TX_SYNC_DONE, .TX_SRC_QUEUE,
        .TX_SRC_SERIAL, .TX_QUEUE_LOOP, .TX_SRC_PRBS, .TX_ENDLESS, .RX_TO_QUEUE,
        .RX_TO_PINS, .RX_QUEUE_LOOP, .RX_ENDLESS, .CCA_PIN);
    host_apb_model i_host_apb_model (.clk(MCLK), .rst(RST), .req, .wr, .addr, .wdata,
        .done, .rdata, .err, .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
        .pwdata(PWDATA), .pready(PREADY), .prdata(PRDATA), .pslverr(PSLVERR));

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    always @(posedge MCLK)
    begin
        if (TX_SYNC_STROBE === 1'b1)
            tx_seen.push_back(TX_SYNC_SYMBOL);
        // done must come with the last nibble, so it records how many were seen
        if (TX_SYNC_DONE === 1'b1)
            tx_done_at = tx_seen.size();
        if (FRAME_SYNC === 1'b1)
            sync_hits++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge MCLK);
        req <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++)
            @(posedge MCLK);
        if (done !== 1'b1)
        begin
            n_mismatch++;
            final_report();
        end
    endtask

    task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rdata, exp);
    endtask

    task automatic ticks(input int n);
        repeat (n)
        begin
            SYMBOL_TICK <= 1'b1;
            @(posedge MCLK);
            SYMBOL_TICK <= 1'b0;
            repeat (3) @(posedge MCLK);
        end
    endtask

    task automatic send_syms(input logic [19:0] s);
        int i;
        for (i = 0; i < 5; i++)
        begin
            RX_SYMBOL <= s[4*i+:4];
            RX_SYMBOL_VALID <= 1'b1;
            @(posedge MCLK);
            RX_SYMBOL_VALID <= 1'b0;
            @(posedge MCLK);
        end
        repeat (4) @(posedge MCLK);
    endtask

    task automatic test_reset;
        rd_check("control", ADDR_MODEM_CONTROL_SECOND, 32'h0);
        rd_check("status", ADDR_SIGNAL_STRENGTH_CCA, 32'he080);
        rd_check("sync", ADDR_SYNC_PATTERN, 32'ha70f);
        rd_check("cca config", ADDR_CCA_CONFIG, 32'h32);
        apb(1'b0, 8'hfc, 32'h0);
        check("unmapped", {err, rdata[30:0]}, 32'h80000000);
    endtask

    task automatic test_modes;
        int t;
        int r;
        logic [31:0] cw;
        for (t = 0; t < 4; t++)
        begin
            // reserved receive value 3 is never selected
            r = (t == 3) ? 0 : t;
            cw = {21'h0, CORRELATOR_THRESHOLD_ADVISED, 1'b0, t[0], t[1:0], r[1:0]};
            apb(1'b1, ADDR_MODEM_CONTROL_SECOND, cw);
            rd_check("control", ADDR_MODEM_CONTROL_SECOND, cw);
            check("phase", PHASE_REVERSED, t[0]);
            check("tx queue", TX_SRC_QUEUE, t == 0 || t == 2);
            check("tx serial", TX_SRC_SERIAL, t == 1);
            check("tx loop", TX_QUEUE_LOOP, t == 2);
            check("tx prbs", TX_SRC_PRBS, t == 3);
            check("tx endless", TX_ENDLESS, t != 0);
            check("rx queue", RX_TO_QUEUE, r != 1);
            check("rx pins", RX_TO_PINS, r == 1);
            check("rx loop", RX_QUEUE_LOOP, r == 2);
            check("rx endless", RX_ENDLESS, r != 0);
        end
    endtask

    task automatic test_sync_tx;
        int i;
        logic [3:0] e;
        tx_seen.delete();
        tx_done_at = 0;
        TX_SYNC_START <= 1'b1;
        @(posedge MCLK);
        TX_SYNC_START <= 1'b0;
        @(posedge MCLK);
        ticks(4);
        check("tx count", tx_seen.size(), 4);
        check("tx done", tx_done_at, 4);
        for (i = 0; i < 4 && tx_seen.size() == 4; i++)
        begin
            e = (SYNC_RESET[4*i+:4] == 4'hf) ? 4'h0 : SYNC_RESET[4*i+:4];
            check("tx nibble", tx_seen[i], e);
        end
    endtask

    task automatic test_search;
        RX_ENABLE <= 1'b1;
        CORR_MAG <= 5'h13;
        repeat (3) @(posedge MCLK);
        check("search low", SFD_SEARCH_EN, 1'b0);
        CORR_MAG <= 5'h14;
        repeat (3) @(posedge MCLK);
        check("search on", SFD_SEARCH_EN, 1'b1);
        PREAMBLE_MATCH <= 1'b1;
        @(posedge MCLK);
        PREAMBLE_MATCH <= 1'b0;
        repeat (3) @(posedge MCLK);
        check("filter hold", FREQ_FILTER_HOLD, 1'b1);
        apb(1'b1, ADDR_MODEM_CONTROL_SECOND, {21'h0, CORRELATOR_THRESHOLD_ADVISED, 6'h20});
        repeat (2) @(posedge MCLK);
        check("filter free", FREQ_FILTER_HOLD, 1'b0);
    endtask

    task automatic test_sync_rx;
        int base;
        apb(1'b1, ADDR_SYNC_PATTERN, 32'h3f21);
        base = sync_hits;
        send_syms(20'h39210);
        check("sync found", sync_hits, base + 1);
        send_syms(20'h39215);
        check("no lead zero", sync_hits, base + 1);
        send_syms(20'h3e210);
        check("dont care", sync_hits, base + 2);
    endtask

    task automatic test_signal_strength_cca;
        SIGNAL_STRENGTH_CCA_SAMPLE <= 8'hce;
        ticks(8);
        rd_check("estimate", ADDR_SIGNAL_STRENGTH_CCA, 32'he0ce);
        rd_check("rx status", ADDR_RX_STATUS, 32'h3);
        RX_PACKET_ACTIVE <= 1'b1;
        repeat (3) @(posedge MCLK);
        check("cca busy", CCA_PIN, 1'b0);
        RX_PACKET_ACTIVE <= 1'b0;
        // only the threshold byte may take write data
        apb(1'b1, ADDR_SIGNAL_STRENGTH_CCA, 32'h1255);
        rd_check("threshold", ADDR_SIGNAL_STRENGTH_CCA, 32'h12ce);
        // level-only mode, hysteresis 2
        apb(1'b1, ADDR_CCA_CONFIG, 32'h12);
        SIGNAL_STRENGTH_CCA_SAMPLE <= 8'h20;
        ticks(8);
        check("cca above", CCA_PIN, 1'b0);
        // packet-only mode ignores the level
        apb(1'b1, ADDR_CCA_CONFIG, 32'h22);
        @(posedge MCLK);
        check("cca no packet", CCA_PIN, 1'b1);
        apb(1'b1, ADDR_CCA_CONFIG, 32'h12);
        SIGNAL_STRENGTH_CCA_SAMPLE <= 8'h11;
        ticks(8);
        check("clear_channel_hysteresis", CCA_PIN, 1'b0);
        SIGNAL_STRENGTH_CCA_SAMPLE <= 8'h0f;
        ticks(8);
        check("cca below", CCA_PIN, 1'b1);
        RX_ENABLE <= 1'b0;
        repeat (2) @(posedge MCLK);
        rd_check("invalid", ADDR_SIGNAL_STRENGTH_CCA, 32'h1280);
        apb(1'b0, ADDR_RX_STATUS, 32'h0);
        check("valid off", rdata[0], 1'b0);
    endtask

    initial
    begin
        RST = 1'b1;
        req = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        RX_ENABLE = 1'b0;
        SYMBOL_TICK = 1'b0;
        SIGNAL_STRENGTH_CCA_SAMPLE = 8'h00;
        CORR_MAG = 5'h00;
        PREAMBLE_MATCH = 1'b0;
        RX_PACKET_ACTIVE = 1'b0;
        RX_SYMBOL = 4'h0;
        RX_SYMBOL_VALID = 1'b0;
        TX_SYNC_START = 1'b0;
        repeat (5) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        test_reset();
        test_modes();
        test_sync_tx();
        test_search();
        test_sync_rx();
        test_signal_strength_cca();
        final_report();
    end
endmodule // tb
`default_nettype wire
